// *** inc/qpio_defines.svh ***
// Functional notes
// [RQ1] Reset sets port 0 latch to all ones and drive type to all zeros.
// [RQ2] Port 0 drive type 0 is open-drain sink, 1 is push-pull.
// [RQ3] Port 0 latch reads at 0000H; pin levels read at 000BH.
// [RQ4] Software sets latch 1 then drive type 0 before using a port 0 input.
// [RQ5] Port 0 pins carry interrupt, serial and UART alternate functions.
// [RQ6] Port 1 direction at 0009H, 1 is output; latch at 0001H.
// [RQ7] Reset clears port 1 direction and latch, so all pins are inputs.
// [RQ8] Port 1 read returns latch for outputs, pin level for inputs.
// [RQ9] Read-modify-write copies input pin levels into port 1 latch bits.
// [RQ10] Software sets latch 1 then direction 1 before timer or divider output.
// [RQ11] Port 2 has three bits; reset sets its latch bits to one.
// [RQ12] Software keeps port 2 latch at one for input or secondary use.
// [RQ13] Dual-clock mode gives port 2 bits 1 and 2 to the slow crystal.
// [RQ14] A falling edge on port 2 bit 0 sets its interrupt latch.
// [RQ15] Port 2 reads return undefined values in bits 7 to 3.
// [RQ16] Stop mode floats port 2 bit 0 regardless of the global drive enable.
// [RQ17] Reset sets port 3 latch to ones; a one lets the pin act as input.
// [RQ18] Port 3 latch reads at 0003H; pin levels read at 000DH.
// [RQ19] Pin levels are sampled when the read is taken; the code returns them four pclk cycles late, after a synchroniser and filter.
// [RQ20] Port outputs change right after the write is taken; the code changes them one pclk cycle later, through a registered pin driver.
// [RQ21] Writes to pin-level registers are ignored.
`ifndef QPIO_DEFINES_SVH
`define QPIO_DEFINES_SVH
`define QPIO_ADDR_P0_LATCH 12'h000
`define QPIO_ADDR_P1_LATCH 12'h001
`define QPIO_ADDR_P2_LATCH 12'h002
`define QPIO_ADDR_P3_LATCH 12'h003
`define QPIO_ADDR_P0_DRIVE 12'h008
`define QPIO_ADDR_P1_DIR 12'h009
`define QPIO_ADDR_P0_PIN 12'h00B
`define QPIO_ADDR_P2_PIN 12'h00C
`define QPIO_ADDR_P3_PIN 12'h00D
`define QPIO_ADDR_P2_CTRL 12'h040
`define QPIO_ADDR_P2_STAT 12'h041
`define QPIO_RST_P0_LATCH 8'hFF
`define QPIO_RST_P0_DRIVE 8'h00
`define QPIO_RST_P1_LATCH 8'h00
`define QPIO_RST_P1_DIR 8'h00
`define QPIO_RST_P2_LATCH 3'h7
`define QPIO_RST_P3_LATCH 8'hFF
`define QPIO_RST_P2_CTRL 3'h4
`define QPIO_CTRL_DUAL_BIT 0
`define QPIO_CTRL_STOP_BIT 1
`define QPIO_CTRL_GLOBAL_PIN_DRIVE_ENABLE_BIT 2
`define QPIO_STAT_IRQ_BIT 0
`endif

// *** inc/qpio_pkg.sv ***
package qpio_pkg;
	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
	} qpio_pins8_type;
	typedef struct packed {
		logic [2:0] o;
		logic [2:0] oe;
	} qpio_pins3_type;
	typedef struct packed {
		logic [11:0] paddr;
		logic psel;
		logic penable;
		logic pwrite;
		logic [31:0] pwdata;
	} qpio_apb_req_type;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} qpio_apb_rsp_type;
endpackage

// *** logic/qpio_top.sv ***
`timescale 1ns/10ps
`include "qpio_defines.svh"
module qpio_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire qpio_pkg::qpio_apb_req_type apb_req,
	output qpio_pkg::qpio_apb_rsp_type apb_rsp,
	input wire logic [7:0] port0_i,
	output qpio_pkg::qpio_pins8_type port0_pins,
	input wire logic [7:0] port1_i,
	output qpio_pkg::qpio_pins8_type port1_pins,
	input wire logic [2:0] port2_i,
	output qpio_pkg::qpio_pins3_type port2_pins,
	input wire logic [7:0] port3_i,
	output qpio_pkg::qpio_pins8_type port3_pins,
	output logic [7:0] port0_alt_in,
	output logic ext_irq_port2
);
	import qpio_pkg::*;

	// ----------------------------------------
	// Pin synchronisers.
	// ----------------------------------------
	function automatic logic [7:0] settle(input logic [7:0] s2, input logic [7:0] s3,
		input logic [7:0] held);
		return (s2 & s3) | (held & (s2 | s3));
	endfunction

	// ----------------------------------------
	// Port 0 pin synchroniser.
	// ----------------------------------------
	logic [7:0] p0_sync1_r;
	logic [7:0] p0_sync2_r;
	logic [7:0] p0_sync3_r;
	logic [7:0] p0_pin_r;
	logic [7:0] p0_pin;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p0_sync1_r <= '0;
			p0_sync2_r <= '0;
			p0_sync3_r <= '0;
			p0_pin_r <= '0;
		end else begin
			p0_sync1_r <= port0_i;
			p0_sync2_r <= p0_sync1_r;
			p0_sync3_r <= p0_sync2_r;
			p0_pin_r <= settle(p0_sync2_r, p0_sync3_r, p0_pin_r);
		end
	end
	assign p0_pin = p0_pin_r;

	// ----------------------------------------
	// Port 1 pin synchroniser.
	// ----------------------------------------
	logic [7:0] p1_sync1_r;
	logic [7:0] p1_sync2_r;
	logic [7:0] p1_sync3_r;
	logic [7:0] p1_pin_r;
	logic [7:0] p1_pin;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p1_sync1_r <= '0;
			p1_sync2_r <= '0;
			p1_sync3_r <= '0;
			p1_pin_r <= '0;
		end else begin
			p1_sync1_r <= port1_i;
			p1_sync2_r <= p1_sync1_r;
			p1_sync3_r <= p1_sync2_r;
			p1_pin_r <= settle(p1_sync2_r, p1_sync3_r, p1_pin_r);
		end
	end
	assign p1_pin = p1_pin_r;

	// ----------------------------------------
	// Port 3 pin synchroniser.
	// ----------------------------------------
	logic [7:0] p3_sync1_r;
	logic [7:0] p3_sync2_r;
	logic [7:0] p3_sync3_r;
	logic [7:0] p3_pin_r;
	logic [7:0] p3_pin;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p3_sync1_r <= '0;
			p3_sync2_r <= '0;
			p3_sync3_r <= '0;
			p3_pin_r <= '0;
		end else begin
			p3_sync1_r <= port3_i;
			p3_sync2_r <= p3_sync1_r;
			p3_sync3_r <= p3_sync2_r;
			p3_pin_r <= settle(p3_sync2_r, p3_sync3_r, p3_pin_r);
		end
	end
	assign p3_pin = p3_pin_r;

	// ----------------------------------------
	// Port 2 pin synchroniser.
	// ----------------------------------------
	logic [2:0] p2_sync1_r;
	logic [2:0] p2_sync2_r;
	logic [2:0] p2_sync3_r;
	logic [2:0] p2_pin_r;
	logic [2:0] p2_pin;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p2_sync1_r <= '0;
			p2_sync2_r <= '0;
			p2_sync3_r <= '0;
			p2_pin_r <= '0;
		end else begin
			p2_sync1_r <= port2_i;
			p2_sync2_r <= p2_sync1_r;
			p2_sync3_r <= p2_sync2_r;
			p2_pin_r <= 3'(settle({5'h00, p2_sync2_r}, {5'h00, p2_sync3_r},
				{5'h00, p2_pin_r}));
		end
	end
	assign p2_pin = p2_pin_r;

	// ----------------------------------------
	// Register writes.
	// ----------------------------------------
	logic wr;
	logic rd;
	assign wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign rd = apb_req.psel && apb_req.penable && !apb_req.pwrite;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
		return a[11:2] == r[9:0];
	endfunction

	logic [7:0] p0_latch_r;
	logic [7:0] p0_drive_r;
	logic [7:0] p1_latch_r;
	logic [7:0] p1_dir_r;
	logic [2:0] p2_latch_r;
	logic [7:0] p3_latch_r;
	logic [2:0] p2_ctrl_r;
	logic [7:0] wd;
	assign wd = apb_req.pwdata[7:0];
	// Pin-level addresses match none of the writable registers below. [RQ21]

	// ----------------------------------------
	// Port 0 output latch.
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p0_latch_r <= `QPIO_RST_P0_LATCH; // [RQ1]
		end else if (wr && hit(apb_req.paddr, `QPIO_ADDR_P0_LATCH)) begin
			p0_latch_r <= wd; // [RQ20]
		end
	end

	// ----------------------------------------
	// Port 0 drive type.
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p0_drive_r <= `QPIO_RST_P0_DRIVE; // [RQ1]
		end else if (wr && hit(apb_req.paddr, `QPIO_ADDR_P0_DRIVE)) begin
			p0_drive_r <= wd;
		end
	end

	// ----------------------------------------
	// Port 1 output latch.
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p1_latch_r <= `QPIO_RST_P1_LATCH; // [RQ7]
		end else if (wr && hit(apb_req.paddr, `QPIO_ADDR_P1_LATCH)) begin
			p1_latch_r <= wd; // [RQ9]
		end
	end

	// ----------------------------------------
	// Port 1 direction.
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p1_dir_r <= `QPIO_RST_P1_DIR; // [RQ7]
		end else if (wr && hit(apb_req.paddr, `QPIO_ADDR_P1_DIR)) begin
			p1_dir_r <= wd; // [RQ6]
		end
	end

	// ----------------------------------------
	// Port 2 output latch.
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p2_latch_r <= `QPIO_RST_P2_LATCH; // [RQ11]
		end else if (wr && hit(apb_req.paddr, `QPIO_ADDR_P2_LATCH)) begin
			p2_latch_r <= wd[2:0];
		end
	end

	// ----------------------------------------
	// Port 3 output latch.
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p3_latch_r <= `QPIO_RST_P3_LATCH; // [RQ17]
		end else if (wr && hit(apb_req.paddr, `QPIO_ADDR_P3_LATCH)) begin
			p3_latch_r <= wd;
		end
	end

	// ----------------------------------------
	// Port 2 mode control.
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p2_ctrl_r <= `QPIO_RST_P2_CTRL;
		end else if (wr && hit(apb_req.paddr, `QPIO_ADDR_P2_CTRL)) begin
			p2_ctrl_r <= wd[2:0];
		end
	end

	// ----------------------------------------
	// Port 2 bit 0 falling-edge interrupt latch.
	// ----------------------------------------
	logic p2_prev_r;
	logic irq_r;
	logic irq_clr;
	assign irq_clr = wr && hit(apb_req.paddr, `QPIO_ADDR_P2_STAT) && wd[`QPIO_STAT_IRQ_BIT];
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			p2_prev_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			p2_prev_r <= p2_pin[0];
			if (p2_prev_r && !p2_pin[0]) begin
				irq_r <= 1'b1; // [RQ14]
			end else if (irq_clr) begin
				irq_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Read data.
	// ----------------------------------------
	logic [7:0] rdat;
	logic hit_any;
	always_comb begin
		rdat = 8'h00;
		hit_any = 1'b1;
		case ({2'b00, apb_req.paddr[11:2]})
			`QPIO_ADDR_P0_LATCH: rdat = p0_latch_r; // [RQ3]
			`QPIO_ADDR_P0_PIN: rdat = p0_pin; // [RQ3] [RQ19]
			`QPIO_ADDR_P0_DRIVE: rdat = p0_drive_r;
			`QPIO_ADDR_P1_LATCH: rdat = (p1_latch_r & p1_dir_r) | (p1_pin & ~p1_dir_r); // [RQ8]
			`QPIO_ADDR_P1_DIR: rdat = p1_dir_r;
			`QPIO_ADDR_P2_LATCH: rdat = {5'h00, p2_latch_r}; // [RQ15]
			`QPIO_ADDR_P2_PIN: rdat = {5'h00, p2_pin}; // [RQ15]
			`QPIO_ADDR_P3_LATCH: rdat = p3_latch_r; // [RQ18]
			`QPIO_ADDR_P3_PIN: rdat = p3_pin; // [RQ18]
			`QPIO_ADDR_P2_CTRL: rdat = {5'h00, p2_ctrl_r};
			`QPIO_ADDR_P2_STAT: rdat = {7'h00, irq_r};
			default: hit_any = 1'b0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			apb_rsp <= '0;
		end else begin
			apb_rsp.pready <= apb_req.psel && !apb_req.penable;
			apb_rsp.pslverr <= apb_req.psel && !apb_req.penable && !hit_any;
			apb_rsp.prdata <= (apb_req.psel && !apb_req.penable && !apb_req.pwrite) ?
				{24'h000000, rdat} : 32'h00000000;
		end
	end

	// ----------------------------------------
	// Pin drivers.
	// ----------------------------------------
	logic global_pin_drive_enable;
	logic dual;
	logic stop;
	assign dual = p2_ctrl_r[`QPIO_CTRL_DUAL_BIT];
	assign stop = p2_ctrl_r[`QPIO_CTRL_STOP_BIT];
	assign global_pin_drive_enable = p2_ctrl_r[`QPIO_CTRL_GLOBAL_PIN_DRIVE_ENABLE_BIT];

	// ----------------------------------------
	// Port 0 driver.
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port0_pins <= '0;
		end else begin
			port0_pins.o <= p0_latch_r;
			port0_pins.oe <= global_pin_drive_enable ? (p0_drive_r | ~p0_latch_r) : 8'h00; // [RQ2]
		end
	end

	// ----------------------------------------
	// Port 1 driver.
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port1_pins <= '0;
		end else begin
			port1_pins.o <= p1_latch_r;
			port1_pins.oe <= global_pin_drive_enable ? p1_dir_r : 8'h00; // [RQ6]
		end
	end

	// ----------------------------------------
	// Port 3 driver.
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port3_pins <= '0;
		end else begin
			port3_pins.o <= p3_latch_r;
			port3_pins.oe <= global_pin_drive_enable ? ~p3_latch_r : 8'h00; // [RQ17]
		end
	end

	// ----------------------------------------
	// Port 2 driver.
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port2_pins <= '0;
		end else begin
			port2_pins.o <= p2_latch_r;
			port2_pins.oe[2:1] <= (global_pin_drive_enable && !dual) ? ~p2_latch_r[2:1] : 2'h0; // [RQ13]
			port2_pins.oe[0] <= global_pin_drive_enable && !stop && !p2_latch_r[0]; // [RQ16]
		end
	end

	// ----------------------------------------
	// Port 0 alternate-function inputs.
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port0_alt_in <= 8'hFF;
		end else begin
			port0_alt_in <= p0_pin; // [RQ5]
		end
	end

	// ----------------------------------------
	// Port 2 interrupt output.
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_irq_port2 <= 1'b0;
		end else begin
			ext_irq_port2 <= irq_r; // [RQ14]
		end
	end
endmodule // qpio_top

// *** verification/qpio_pin_model.sv ***
`timescale 1ns/10ps
// ----------
// Board pins.
// ----------
module qpio_pin_model #(parameter int W = 8) (
	input wire logic [W-1:0] o,
	input wire logic [W-1:0] oe,
	input wire logic [W-1:0] ext,
	output logic [W-1:0] lvl
);
	assign lvl = (o & oe) | (ext & ~oe);
endmodule // qpio_pin_model

// *** verification/qpio_props.sv ***
`timescale 1ns/10ps
// ------------
// Port checks.
// ------------
module qpio_props (
	input wire logic pclk,
	input wire logic presetn,
	input wire qpio_pkg::qpio_apb_req_type apb_req,
	input wire qpio_pkg::qpio_apb_rsp_type apb_rsp,
	input wire qpio_pkg::qpio_pins8_type port0_pins
);
	import qpio_pkg::*;
	logic wr;
	assign wr = apb_req.psel && apb_req.penable && apb_rsp.pready && apb_req.pwrite;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_next: assert property (apb_req.psel && !apb_req.penable |=> apb_rsp.pready)
		else $error("no pready");
	a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("long pready");
	a_idle_quiet: assert property (!apb_req.psel |=> !apb_rsp.pready)
		else $error("stray pready");
	a_err_ready: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("stray error");
	a_rd_upper: assert property (apb_rsp.pready |-> apb_rsp.prdata[31:8] == 24'h000000)
		else $error("upper bits set");
	a_p0_write: assert property (wr && apb_req.paddr == 12'h000 |->
		##3 port0_pins.o == $past(apb_req.pwdata[7:0], 3)) else $error("latch not out");
	a_ro_ignore: assert property (wr && apb_req.paddr == 12'h02C |->
		##3 port0_pins.o == $past(port0_pins.o, 3)) else $error("pin write took");
	a_p0_sink: assert property ($past(presetn) |-> (port0_pins.oe | port0_pins.o) == 8'hFF)
		else $error("low not driven");
endmodule // qpio_props
bind qpio_top qpio_props u_props (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
	.apb_rsp(apb_rsp), .port0_pins(port0_pins));

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
// ----------
// Bench top.
// ----------
module tb_top;
	import qpio_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	qpio_apb_req_type rq = '0;
	qpio_apb_rsp_type rs;
	qpio_pins8_type p0, p1, p3;
	qpio_pins3_type p2;
	logic [7:0] e0 = 8'h00, e1 = 8'h00, e3 = 8'h00, l0, l1, l3, alt, v, d, t;
	logic [2:0] e2 = 3'h0, l2;
	logic [31:0] rd;
	logic er, irq;
	int failures = 0, num_checks = 0;
	logic [11:0] ra [6] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h020, 12'h024};
	logic [7:0] rv [6] = '{8'hFF, 8'h00, 8'h07, 8'hFF, 8'h00, 8'h00};
	always #50 pclk = ~pclk;
	qpio_top uut (.pclk(pclk), .presetn(presetn), .apb_req(rq), .apb_rsp(rs), .port0_i(l0),
		.port0_pins(p0), .port1_i(l1), .port1_pins(p1), .port2_i(l2), .port2_pins(p2),
		.port3_i(l3), .port3_pins(p3), .port0_alt_in(alt), .ext_irq_port2(irq));
	qpio_pin_model m0 (.o(p0.o), .oe(p0.oe), .ext(e0), .lvl(l0));
	qpio_pin_model m1 (.o(p1.o), .oe(p1.oe), .ext(e1), .lvl(l1));
	qpio_pin_model #(.W(3)) m2 (.o(p2.o), .oe(p2.oe), .ext(e2), .lvl(l2));
	qpio_pin_model m3 (.o(p3.o), .oe(p3.oe), .ext(e3), .lvl(l3));
	task automatic print_verdict;
		if (failures == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			failures++;
			$display("wrong value at %0t: got %h want %h", $time, g, x);
		end
	endtask
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] dat);
		int n;
		@(posedge pclk);
		rq <= '{a, 1'b1, 1'b0, w, dat};
		@(posedge pclk);
		rq.penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (rs.pready !== 1'b1 && n < 20);
		rd = rs.prdata;
		er = rs.pslverr;
		rq.psel <= 1'b0;
		rq.penable <= 1'b0;
		if (rs.pready !== 1'b1) begin
			failures++;
			$display("wrong value at %0t: no pready", $time);
			print_verdict();
		end
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0);
		chk(rd, x);
	endtask
	task automatic idle;
		repeat (8) @(posedge pclk);
	endtask
	initial begin
		void'($urandom(18003));
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			rdc(ra[i], {24'h0, rv[i]});
		end
		v = 8'($urandom);
		t = 8'($urandom);
		e0 <= 8'($urandom);
		bus(1'b1, 12'h000, {24'h0, v});
		bus(1'b1, 12'h020, {24'h0, t});
		idle();
		rdc(12'h000, {24'h0, v});
		rdc(12'h02C, {24'h0, v & (t | e0)});
		chk({24'h0, alt}, {24'h0, v & (t | e0)});
		bus(1'b1, 12'h02C, $urandom);
		rdc(12'h000, {24'h0, v});
		rdc(12'h020, {24'h0, t});
		bus(1'b1, 12'h000, 32'hFF);
		bus(1'b1, 12'h020, 32'h0);
		idle();
		rdc(12'h02C, {24'h0, e0});
		d = 8'($urandom);
		v = 8'($urandom);
		e1 <= 8'($urandom);
		bus(1'b1, 12'h024, {24'h0, d});
		bus(1'b1, 12'h004, {24'h0, v});
		idle();
		rdc(12'h004, {24'h0, (v & d) | (e1 & ~d)});
		bus(1'b1, 12'h004, rd);
		bus(1'b1, 12'h024, 32'hFF);
		idle();
		rdc(12'h004, {24'h0, (v & d) | (e1 & ~d)});
		bus(1'b1, 12'h004, 32'hFF);
		bus(1'b1, 12'h024, 32'hFF);
		idle();
		chk({16'h0, p1.o, p1.oe}, 32'h0000FFFF);
		v = 8'($urandom);
		e3 <= 8'($urandom);
		bus(1'b1, 12'h00C, {24'h0, v});
		idle();
		rdc(12'h034, {24'h0, v & e3});
		e2 <= 3'h7;
		idle();
		rdc(12'h030, 32'h7);
		e2 <= 3'h6;
		idle();
		chk({31'h0, irq}, 32'h1);
		bus(1'b1, 12'h104, 32'h1);
		idle();
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, 12'h008, 32'h0);
		idle();
		chk({29'h0, p2.oe}, 32'h7);
		bus(1'b1, 12'h100, 32'h6);
		idle();
		chk({31'h0, p2.oe[0]}, 32'h0);
		bus(1'b1, 12'h100, 32'h5);
		idle();
		chk({29'h0, p2.oe}, 32'h1);
		bus(1'b0, 12'h200, 32'h0);
		chk({er, rd[30:0]}, 32'h80000000);
		print_verdict();
	end
endmodule // tb_top
